// ==== core/atpwm_pkg.sv ====
package atpwm_pkg;
   // -------------------------------------------------------------
   // register map (word indices, taken from ADR_I[5:2])
   // -------------------------------------------------------------
   localparam logic [3:0] ADR_CTRL_A  = 4'h0;
   localparam logic [3:0] ADR_CTRL_B  = 4'h1;
   localparam logic [3:0] ADR_COUNT   = 4'h2;
   localparam logic [3:0] ADR_CMP_A   = 4'h3;
   localparam logic [3:0] ADR_CMP_B   = 4'h4;
   localparam logic [3:0] ADR_ASYNC   = 4'h5;
   localparam logic [3:0] ADR_GTCTRL  = 4'h6;
   localparam logic [3:0] ADR_FLAGS   = 4'h7;
   localparam logic [3:0] ADR_PINDIR  = 4'h8;
   // control A fields
   localparam int MODA_HI = 7;
   localparam int MODA_LO = 6;
   localparam int MODB_HI = 5;
   localparam int MODB_LO = 4;
   localparam int WGM_HI  = 1;
   // control B fields
   localparam int WGM2_BIT = 3;
   localparam int CS_HI    = 2;
   // async status fields, and the prescaler reset bit of the general control register
   localparam int AS_BIT  = 5;
   localparam int UB_CNT  = 4;
   localparam int UB_CA   = 3;
   localparam int UB_CB   = 2;
   localparam int UB_CRA  = 1;
   localparam int UB_CRB  = 0;
   localparam int PSR_BIT = 1;
   // flag register bits
   localparam int FL_OVF = 0;
   localparam int FL_CMA = 1;
   localparam int FL_CMB = 2;
   // values
   localparam logic [7:0] CNT_MAX    = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [2:0] WGM_PC_FF  = 3'h1;
   localparam logic [2:0] WGM_PC_OCA = 3'h5;
   localparam logic [1:0] COM_NONINV = 2'h2;
   localparam logic [1:0] COM_INV    = 2'h3;
   localparam logic [1:0] SYNC_EDGES = 2'h2;
   localparam int         FLAG_SYNC_CYC = 3;
   localparam int         PRE_W      = 10;
endpackage

// ==== core/atpwm_timer.sv ====
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
module atpwm_timer
   import atpwm_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET,
   // wishbone slave
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [5:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   // oscillator pin (sampled level)
   input  wire logic        OSC_IN_PIN,
   // compare pins
   output logic             COMPARE_OUTPUT_A,
   output logic             COMPARE_OUTPUT_A_OE,
   output logic             COMPARE_OUTPUT_B,
   output logic             COMPARE_OUTPUT_B_OE,
   // port release of oscillator pins, sticky overflow flag copy
   output logic             OSC_PINS_TAKEN,
   output logic             OVERFLOW_FLAG
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] ctrl_a_reg, ctrl_b_reg, count_reg, cmp_a_reg, cmp_b_reg;
   logic [7:0] hold_reg [5];
   logic [4:0] busy_reg;
   logic [1:0] edge_cnt_reg [5];
   logic       async_sel_reg, dir_down_reg, ack_reg;
   logic [2:0] flags_reg;
   logic [1:0] pin_dir_reg;
   logic [PRE_W-1:0] pre_reg;
   logic [7:0] read_count_reg;
   logic       osc_q1_reg, osc_q2_reg, osc_q3_reg;
   logic       out_a_reg, out_b_reg;
   // ---------------------------------------------------------------
   // timer source clock as enable
   // ---------------------------------------------------------------
   logic osc_rise, src_tick, tick, wr, rd_hit;
   logic [7:0] top_val, wdat;
   logic [3:0] widx;
   logic [2:0] wgm, cs;
   logic       pc_mode;
   always_ff @(posedge CLK) begin
      osc_q1_reg <= OSC_IN_PIN;
      osc_q2_reg <= osc_q1_reg;
      osc_q3_reg <= osc_q2_reg;
   end
   assign osc_rise = osc_q2_reg & ~osc_q3_reg;
   assign src_tick = async_sel_reg ? osc_rise : 1'b1;
   assign wgm = {ctrl_b_reg[WGM2_BIT], ctrl_a_reg[WGM_HI:0]};
   assign cs  = ctrl_b_reg[CS_HI:0];
   assign pc_mode = (wgm == WGM_PC_FF) || (wgm == WGM_PC_OCA);
   assign top_val = (wgm == WGM_PC_OCA) ? cmp_a_reg : CNT_MAX;

   always_ff @(posedge CLK) begin
      if (RESET || (wr && widx == ADR_GTCTRL && wdat[PSR_BIT]))
         pre_reg <= '0;
      else if (src_tick)
         pre_reg <= pre_reg + 1'b1;
   end
   always_comb begin
      case (cs)
         3'h1: tick = src_tick;
         3'h2: tick = src_tick && (pre_reg[2:0] == 3'h7);
         3'h3: tick = src_tick && (pre_reg[4:0] == 5'h1F);
         3'h4: tick = src_tick && (pre_reg[5:0] == 6'h3F);
         3'h5: tick = src_tick && (pre_reg[6:0] == 7'h7F);
         3'h6: tick = src_tick && (pre_reg[7:0] == 8'hFF);
         3'h7: tick = src_tick && (&pre_reg);
         default: tick = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   assign wr   = CYC_I && STB_I && WE_I && !ack_reg && SEL_I[0];
   assign widx = ADR_I[5:2];
   assign wdat = DAT_I[7:0];
   assign rd_hit = CYC_I && STB_I && !ack_reg;
   always_ff @(posedge CLK) begin
      if (RESET)
         ack_reg <= 1'b0;
      else
         ack_reg <= rd_hit;
   end
   // acknowledge straight from its flip-flop
   assign ACK_O = ack_reg;
   always_ff @(posedge CLK) begin
      if (RESET)
         DAT_O <= '0;
      else if (rd_hit && !WE_I) begin
         case (widx)
            ADR_CTRL_A: DAT_O <= {24'h0, ctrl_a_reg & 8'hF3};
            ADR_CTRL_B: DAT_O <= {24'h0, ctrl_b_reg};
            ADR_COUNT:  DAT_O <= {24'h0, read_count_reg};
            ADR_CMP_A:  DAT_O <= {24'h0, cmp_a_reg};
            ADR_CMP_B:  DAT_O <= {24'h0, cmp_b_reg};
            ADR_ASYNC:  DAT_O <= {26'h0, async_sel_reg, busy_reg};
            ADR_FLAGS:  DAT_O <= {29'h0, flags_reg};
            ADR_PINDIR: DAT_O <= {30'h0, pin_dir_reg};
            default:    DAT_O <= '0;
         endcase
      end
   end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         async_sel_reg <= 1'b0;
         pin_dir_reg   <= 2'h0;
      end else if (wr && widx == ADR_ASYNC)
         async_sel_reg <= wdat[AS_BIT];
      else if (wr && widx == ADR_PINDIR)
         pin_dir_reg <= wdat[1:0];
   end

   // ---------------------------------------------------------------
   // holding registers, one per target (count, cmpA, cmpB, ctlA, ctlB)
   // ---------------------------------------------------------------
   logic [4:0] wsel, commit;
   assign wsel = {widx == ADR_COUNT, widx == ADR_CMP_A, widx == ADR_CMP_B,
                  widx == ADR_CTRL_A, widx == ADR_CTRL_B};
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_hold
         // hold value, busy until two edges
         always_ff @(posedge CLK) begin
            if (RESET) begin
               busy_reg[g]     <= 1'b0;
               edge_cnt_reg[g] <= 2'h0;
               hold_reg[g]     <= 8'h00;
            end else if (wr && wsel[g]) begin
               hold_reg[g]     <= wdat;
               busy_reg[g]     <= async_sel_reg;
               edge_cnt_reg[g] <= 2'h0;
            end else if (busy_reg[g] && osc_rise) begin
               edge_cnt_reg[g] <= edge_cnt_reg[g] + 2'h1;
               if (edge_cnt_reg[g] + 2'h1 == SYNC_EDGES)
                  busy_reg[g] <= 1'b0;
            end
         end
         assign commit[g] = async_sel_reg
                          ? (busy_reg[g] && osc_rise
                             && edge_cnt_reg[g] + 2'h1 == SYNC_EDGES)
                          : (wr && wsel[g]);
      end
   endgenerate
   logic [7:0] cval [5];
   always_comb begin
      for (int i = 0; i < 5; i++)
         cval[i] = async_sel_reg ? hold_reg[i] : wdat;
   end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctrl_a_reg <= 8'h00;
         ctrl_b_reg <= 8'h00;
         cmp_a_reg  <= 8'h00;
         cmp_b_reg  <= 8'h00;
      end else begin
         if (commit[3]) cmp_a_reg  <= cval[3];
         if (commit[2]) cmp_b_reg  <= cval[2];
         if (commit[1]) ctrl_a_reg <= cval[1];
         if (commit[0]) ctrl_b_reg <= cval[0];
      end
   end

   // ---------------------------------------------------------------
   // dual-slope counter
   // ---------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         count_reg    <= CNT_BOTTOM;
         dir_down_reg <= 1'b0;
      end else if (commit[4])
         count_reg <= cval[4];
      else if (tick && pc_mode) begin
         // up to top, top seen one tick, down
         if (!dir_down_reg) begin
            if (count_reg >= top_val) begin
               dir_down_reg <= 1'b1;
               if (count_reg != CNT_BOTTOM)
                  count_reg <= count_reg - 8'h01;
            end else
               count_reg <= count_reg + 8'h01;
         end else begin
            if (count_reg == CNT_BOTTOM) begin
               dir_down_reg <= 1'b0;
               count_reg    <= count_reg + 8'h01;
            end else
               count_reg <= count_reg - 8'h01;
         end
      end
   end
   // read copy refreshed per timer edge
   always_ff @(posedge CLK) begin
      if (RESET)
         read_count_reg <= CNT_BOTTOM;
      else if (src_tick)
         read_count_reg <= count_reg;
   end

   // ---------------------------------------------------------------
   // compare outputs
   // ---------------------------------------------------------------
   logic cmp_block, at_bottom;
   logic [1:0] mod_a, mod_b;
   assign cmp_block = busy_reg[4] | busy_reg[3] | busy_reg[2];
   assign at_bottom = tick && pc_mode && dir_down_reg
                      && count_reg == CNT_BOTTOM;
   assign mod_a = ctrl_a_reg[MODA_HI:MODA_LO];
   assign mod_b = ctrl_a_reg[MODB_HI:MODB_LO];
   function automatic logic next_out(input logic cur, input logic [1:0] md,
                                     input logic [7:0] cv, input logic dn);
      logic inv;
      inv = (md == COM_INV);
      next_out = cur;
      if (md == COM_NONINV || md == COM_INV) begin
         if (cv == CNT_BOTTOM)
            next_out = inv;
         else if (cv == CNT_MAX)
            next_out = !inv;
         else
            next_out = dn ? !inv : inv;
      end
   endfunction
   always_ff @(posedge CLK) begin
      if (RESET) begin
         out_a_reg <= 1'b0;
         out_b_reg <= 1'b0;
      end else if (at_bottom) begin
         if (mod_a[1])
            out_a_reg <= (cmp_a_reg == CNT_BOTTOM) ? mod_a[0] : !mod_a[0];
         if (mod_b[1])
            out_b_reg <= (cmp_b_reg == CNT_BOTTOM) ? mod_b[0] : !mod_b[0];
      end else if (tick && pc_mode && !cmp_block) begin
         if (count_reg == cmp_a_reg)
            out_a_reg <= next_out(out_a_reg, mod_a, cmp_a_reg, dir_down_reg);
         if (count_reg == cmp_b_reg)
            out_b_reg <= next_out(out_b_reg, mod_b, cmp_b_reg, dir_down_reg);
      end
   end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         COMPARE_OUTPUT_A    <= 1'b0;
         COMPARE_OUTPUT_B    <= 1'b0;
         COMPARE_OUTPUT_A_OE <= 1'b0;
         COMPARE_OUTPUT_B_OE <= 1'b0;
         OSC_PINS_TAKEN      <= 1'b0;
      end else begin
         COMPARE_OUTPUT_A    <= out_a_reg;
         COMPARE_OUTPUT_B    <= out_b_reg;
         COMPARE_OUTPUT_A_OE <= pin_dir_reg[0] && mod_a != 2'h0;
         COMPARE_OUTPUT_B_OE <= pin_dir_reg[1] && mod_b != 2'h0;
         OSC_PINS_TAKEN      <= async_sel_reg;
      end
   end

   // ---------------------------------------------------------------
   // flags: sticky, write one to clear, set wins
   // ---------------------------------------------------------------
   logic [2:0] ev;
   assign ev = {tick && pc_mode && !cmp_block && count_reg == cmp_b_reg,
                tick && pc_mode && !cmp_block && count_reg == cmp_a_reg,
                at_bottom};
   // async events delayed before flag set
   logic [2:0] ev_q [FLAG_SYNC_CYC];
   always_ff @(posedge CLK) begin
      if (RESET) begin
         for (int i = 0; i < FLAG_SYNC_CYC; i++) ev_q[i] <= 3'h0;
      end else begin
         ev_q[0] <= ev;
         for (int i = 1; i < FLAG_SYNC_CYC; i++) ev_q[i] <= ev_q[i-1];
      end
   end
   logic [2:0] ev_in, clr;
   assign ev_in = async_sel_reg ? ev_q[FLAG_SYNC_CYC-1] : ev;
   assign clr = (wr && widx == ADR_FLAGS) ? wdat[2:0] : 3'h0;
   always_ff @(posedge CLK) begin
      if (RESET) begin
         flags_reg     <= 3'h0;
         OVERFLOW_FLAG <= 1'b0;
      end else begin
         flags_reg     <= (flags_reg & ~clr) | ev_in;
         OVERFLOW_FLAG <= (flags_reg[FL_OVF] & ~clr[FL_OVF]) | ev_in[FL_OVF];
      end
   end
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // top held one tick
   AST_TOP_REVERSE: assert property (@(posedge CLK) disable iff (RESET)
      tick && pc_mode && !dir_down_reg && count_reg == top_val && !commit[4]
      && top_val != CNT_BOTTOM
      |=> dir_down_reg && count_reg == $past(count_reg) - 8'h01)
      else $error("no reversal at top");
   AST_OVF_SET: assert property (@(posedge CLK) disable iff (RESET)
      at_bottom && !async_sel_reg |=> flags_reg[FL_OVF])
      else $error("overflow flag missed");
   AST_BUSY_SET: assert property (@(posedge CLK) disable iff (RESET)
      wr && widx == ADR_CMP_A && async_sel_reg |=> busy_reg[3])
      else $error("busy not set");
   AST_COUNT_UP: assert property (@(posedge CLK) disable iff (RESET)
      tick && pc_mode && !dir_down_reg && count_reg < top_val && !commit[4]
      |=> count_reg == $past(count_reg) + 8'h01)
      else $error("count did not rise");
   AST_OE_DIR: assert property (@(posedge CLK) disable iff (RESET)
      !pin_dir_reg[0] |=> !COMPARE_OUTPUT_A_OE)
      else $error("pin driven as input");
   AST_SYNC_WR: assert property (@(posedge CLK) disable iff (RESET)
      wr && widx == ADR_CMP_B && !async_sel_reg |=> cmp_b_reg == $past(wdat))
      else $error("compare write lost");
   AST_STOP: assert property (@(posedge CLK) disable iff (RESET)
      cs == 3'h0 && !commit[4] |=> count_reg == $past(count_reg))
      else $error("stopped counter moved");
   AST_PSR: assert property (@(posedge CLK) disable iff (RESET)
      wr && widx == ADR_GTCTRL && wdat[PSR_BIT] |=> pre_reg == '0)
      else $error("prescaler not cleared");
   COV_REVERSE: cover property (@(posedge CLK) at_bottom);
   COV_ASYNC:   cover property (@(posedge CLK) commit[3] && async_sel_reg);
   COV_PWM:     cover property (@(posedge CLK) $rose(out_a_reg));
endmodule // atpwm_timer

// ==== verif/atpwm_osc_model.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------
// watch crystal model
// ---------------------------------------------------------------
module atpwm_osc_model #(
   parameter int HALF_NS = 15259   // about half of a 32.768 kHz period
) (
   // oscillator level
   output logic osc_out
);
   initial begin
      osc_out = 1'b0;
      #37;                          // phase unrelated to the bus clock
      forever #(HALF_NS) osc_out = ~osc_out;
   end
endmodule // atpwm_osc_model

// ==== verif/atpwm_timer_tb_top.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD t=%0t got %0h exp %0h", $time, (g), (e)); end end
// ---------------------------------------------------------------
// testbench top
// ---------------------------------------------------------------
module atpwm_timer_tb_top
   import atpwm_pkg::*;
();
   localparam int LIM = 40000;
   logic        clk, reset, cyc, stb, we, ack, osc;
   logic        oa, oa_oe, ob, ob_oe, taken, ovf;
   logic [5:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat_w, dat_r;
   logic [7:0]  q;
   int          error_cnt, n_checks, lo, hi;
   int          divs[3] = '{1, 8, 32};
   logic [3:0]  ra[6] = '{ADR_CTRL_A, ADR_CTRL_B, ADR_COUNT, ADR_ASYNC,
                          ADR_FLAGS, 4'h9};
   logic [7:0]  xm[4] = '{8'h81, 8'h81, 8'hC1, 8'hC1};
   logic [7:0]  xc[4] = '{8'h00, 8'hFF, 8'h00, 8'hFF};
   logic        xe[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   time         t0;

   // design and crystal
   atpwm_timer u_atpwm_timer (.CLK(clk), .RESET(reset), .CYC_I(cyc),
      .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w),
      .DAT_O(dat_r), .ACK_O(ack), .OSC_IN_PIN(osc),
      .COMPARE_OUTPUT_A(oa), .COMPARE_OUTPUT_A_OE(oa_oe),
      .COMPARE_OUTPUT_B(ob), .COMPARE_OUTPUT_B_OE(ob_oe),
      .OSC_PINS_TAKEN(taken), .OVERFLOW_FLAG(ovf));
   atpwm_osc_model #(.HALF_NS(400)) u_atpwm_osc_model (.osc_out(osc));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // one classic wishbone cycle, held until ack is sampled
   task automatic xfer(input logic w, input logic [3:0] a,
                       input logic [7:0] d, output logic [7:0] r);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {a, 2'b00};
      dat_w <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = dat_r[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1) begin
         `CHK(ack, 1'b1)
         wrap_up();
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] r;
      xfer(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] r);
      xfer(1'b0, a, 8'h00, r);
   endtask

   function automatic logic pin(input bit b);
      return b ? ob : oa;
   endfunction

   // low and high time after a falling edge, in clock cycles
   task automatic meas(input bit b, output int l, output int h);
      int n;
      logic p, s;
      n = 0;
      p = pin(b);
      do begin
         @(posedge clk);
         n++;
         s = p;
         p = pin(b);
      end while (!(s === 1'b1 && p === 1'b0) && n < LIM);
      if (n >= LIM) begin
         `CHK(n, 0)
         wrap_up();
      end
      l = 0;
      do begin @(posedge clk); l++; end while (pin(b) === 1'b0 && l < LIM);
      h = 0;
      do begin @(posedge clk); h++; end while (pin(b) === 1'b1 && h < LIM);
   endtask

   // bounded wait for a rising level on osc or ovf
   task automatic wait_rise(input bit use_ovf);
      int n;
      logic p, s;
      n = 0;
      p = use_ovf ? ovf : osc;
      do begin
         @(posedge clk);
         n++;
         s = p;
         p = use_ovf ? ovf : osc;
      end while (!(s === 1'b0 && p === 1'b1) && n < 2000);
      if (n >= 2000) begin
         `CHK(n, 0)
         wrap_up();
      end
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      error_cnt = 0;
      n_checks = 0;
      reset = 1'b1;
      {cyc, stb, we} = 3'h0;
      adr = 6'h00;
      sel = 4'hF;
      dat_w = 32'h0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      // reset values and an unmapped word
      foreach (ra[i]) begin
         rd(ra[i], q);
         `CHK(q, 8'h00)
      end
      wr(ADR_PINDIR, 8'h03);
      wr(ADR_CMP_A, 8'h80);
      wr(ADR_CTRL_A, 8'h81);
      foreach (divs[i]) begin
         wr(ADR_CTRL_B, 8'(i + 1));
         meas(1'b0, lo, hi);
         `CHK(lo, 254 * divs[i])
         `CHK(hi, 256 * divs[i])
      end
      `CHK(oa_oe, 1'b1)
      wr(ADR_CTRL_B, 8'h01);
      wr(ADR_CTRL_A, 8'hC1);
      meas(1'b0, lo, hi);
      `CHK(lo, 256)
      `CHK(hi, 254)
      wr(ADR_FLAGS, 8'h01);
      wait_rise(1'b1);
      t0 = $time;
      wr(ADR_FLAGS, 8'h01);
      wait_rise(1'b1);
      `CHK(int'(($time - t0) / 10), 510)
      foreach (xm[i]) begin
         int bad;
         bad = 0;
         wr(ADR_CTRL_A, xm[i]);
         wr(ADR_CMP_A, xc[i]);
         repeat (520) @(posedge clk);
         repeat (520) begin
            @(posedge clk);
            if (oa !== xe[i]) bad++;
         end
         `CHK(bad, 0)
      end
      // top from compare A, output on channel B
      wr(ADR_CTRL_A, 8'h21);
      wr(ADR_CMP_A, 8'h40);
      wr(ADR_CMP_B, 8'h10);
      wr(ADR_CTRL_B, 8'h09);
      meas(1'b1, lo, hi);
      `CHK(lo, 96)
      `CHK(hi, 32)
      `CHK(ob_oe, 1'b1)
      wr(ADR_PINDIR, 8'h00);
      repeat (2) @(posedge clk);
      `CHK(oa_oe, 1'b0)
      `CHK(ob_oe, 1'b0)
      wr(ADR_GTCTRL, 8'h02);
      rd(ADR_GTCTRL, q);
      `CHK(q, 8'h00)
      // async write through the holding register
      // stop timer, select source, then rewrite
      wr(ADR_CTRL_B, 8'h00);
      wr(ADR_CTRL_A, 8'h00);
      wr(ADR_ASYNC, 8'h20);
      repeat (2) @(posedge clk);
      `CHK(taken, 1'b1)
      wait_rise(1'b0);
      wr(ADR_COUNT, 8'h5A);
      rd(ADR_ASYNC, q);
      `CHK(q, 8'h30)
      wait_rise(1'b0);
      repeat (4) @(posedge clk);
      rd(ADR_ASYNC, q);
      `CHK(q, 8'h30)
      wait_rise(1'b0);
      repeat (4) @(posedge clk);
      rd(ADR_ASYNC, q);
      `CHK(q, 8'h20)
      // busy cleared, count copy refreshed next edge
      wait_rise(1'b0);
      repeat (4) @(posedge clk);
      rd(ADR_COUNT, q);
      `CHK(q, 8'h5A)
      wrap_up();
   end
endmodule // atpwm_timer_tb_top
